// *** logic/cspc_pkg.sv ***
// ==========================================================
// socket power control constants
package cspc_pkg;
  // bus data width
  localparam int DATA_W = 32;
  // register indices, byte address is four times the index
  localparam logic [11:0] STS_IDX = 12'h801;
  localparam logic [11:0] PWR_IDX = 12'h802;
  localparam logic [11:0] IGC_IDX = 12'h803;
  localparam logic [11:0] CFG_IDX = 12'h810;
  localparam logic [11:0] LEG_STS_IDX = 12'h001;
  localparam logic [11:0] LEG_PWR_IDX = 12'h002;
  localparam logic [11:0] LEG_IGC_IDX = 12'h003;
  localparam logic [11:0] LEG_B_BASE = 12'h040;
  // power control fields
  localparam int COE_BIT = 7;
  localparam int AUTO_BIT = 5;
  localparam int SUPEN_BIT = 4;
  localparam int VCC_LSB = 3;
  localparam int VPP_LSB = 0;
  // status fields
  localparam int PFLAG_BIT = 6;
  localparam int CD2_BIT = 3;
  localparam int CD1_BIT = 2;
  // config fields
  localparam int REV_LSB = 0;
  localparam int SYSSEL_BIT = 4;
  localparam int PME_BIT = 5;
  // writable and power-management masks per layout, and the general control pm mask
  localparam logic [7:0] ORIG_WMASK = 8'hB3;
  localparam logic [7:0] LATER_WMASK = 8'h9B;
  localparam logic [7:0] ORIG_PMMASK = 8'h20;
  localparam logic [7:0] LATER_PMMASK = 8'h9B;
  localparam logic [7:0] IGC_PMMASK = 8'h60;
  // reset values
  localparam logic [7:0] PWR_RST = 8'h00;
  localparam logic [7:0] IGC_RST = 8'h00;
  localparam logic [3:0] REV_RST = 4'h4;
  localparam logic [3:0] REV_ORIG = 4'h2;
  // switch request encodings
  localparam logic [1:0] VCC_OFF = 2'h0;
  localparam logic [1:0] VCC_5V = 2'h2;
  localparam logic [1:0] VCC_3V3 = 2'h3;
  localparam logic [1:0] VPP_OFF = 2'h0;
  localparam logic [1:0] VPP_VCC = 2'h1;
  localparam logic [1:0] VPP_12V = 2'h2;
endpackage

// *** logic/cspc_top.sv ***
`timescale 1ns/1ns
module cspc_top
#(
  parameter int ADDR_W = 14,
  parameter bit CARD_B = 1'b0
)
(
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [cspc_pkg::DATA_W-1:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [cspc_pkg::DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic BUS_RESET_INPUT_B,
  input wire logic CD1_B,
  input wire logic CD2_B,
  output logic CARD_OUTPUT_ENABLE,
  output logic [1:0] SUPPLY_VOLTAGE_REQUEST,
  output logic [1:0] PROG_VOLTAGE_REQUEST
);
  import cspc_pkg::*;

  // ========================================================
  // elaboration checks
  if (ADDR_W < 14)
  begin : g_bad_addr
    $error("address bus too narrow for the register map");
  end

  // ========================================================
  // address decode
  localparam logic [11:0] LEG = CARD_B ? LEG_B_BASE : 12'h000;
  logic [11:0] idx;
  logic word_ok;
  logic sel_sts;
  logic sel_pwr;
  logic sel_igc;
  logic sel_cfg;
  logic mapped;
  logic setup;
  logic wr;

  // word index and alignment of the current address
  assign idx = PADDR[13:2];
  assign word_ok = (PADDR[1:0] == 2'h0) && ((PADDR >> 14) == '0);
  // socket offsets, and legacy aliases for all but config
  assign sel_sts = word_ok && (idx == STS_IDX || idx == (LEG_STS_IDX | LEG));
  assign sel_pwr = word_ok && (idx == PWR_IDX || idx == (LEG_PWR_IDX | LEG));
  assign sel_igc = word_ok && (idx == IGC_IDX || idx == (LEG_IGC_IDX | LEG));
  assign sel_cfg = word_ok && (idx == CFG_IDX);
  assign mapped = sel_sts || sel_pwr || sel_igc || sel_cfg;
  // bus phases
  assign setup = PSEL && !PENABLE;
  assign wr = PSEL && PENABLE && PREADY && PWRITE && PSTRB[0];

  // ========================================================
  // register state
  logic [7:0] pwr_ctl;
  logic [7:0] igc;
  logic [3:0] cfg_rev;
  logic sys_sel;
  logic pme_en;
  logic orig;
  logic [7:0] wmask;
  logic [7:0] pmmask;
  logic [7:0] pwr_view;

  // layout chosen by the revision field
  assign orig = (cfg_rev == REV_ORIG);
  assign wmask = orig ? ORIG_WMASK : LATER_WMASK;
  assign pmmask = orig ? ORIG_PMMASK : LATER_PMMASK;
  // reserved bits of the active layout read as zero
  assign pwr_view = pwr_ctl & wmask;

  // power control register, bus reset respects pme
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
      pwr_ctl <= PWR_RST;
    else if (CE)
    begin
      if (!BUS_RESET_INPUT_B)
        pwr_ctl <= pme_en ? (pwr_ctl & pmmask) : PWR_RST;
      else if (wr && sel_pwr)
        pwr_ctl <= PWDATA[7:0] & wmask;
    end
  end

  // general control register, plain read/write
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
      igc <= IGC_RST;
    else if (CE)
    begin
      if (!BUS_RESET_INPUT_B)
        igc <= pme_en ? (igc & IGC_PMMASK) : IGC_RST;
      else if (wr && sel_igc)
        igc <= PWDATA[7:0];
    end
  end

  // config register, loaded with its reset values by global reset only
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      cfg_rev <= REV_RST;
      sys_sel <= 1'b0;
      pme_en <= 1'b0;
    end
    else if (CE && wr && sel_cfg)
    begin
      cfg_rev <= PWDATA[REV_LSB +: 4];
      sys_sel <= PWDATA[SYSSEL_BIT];
      pme_en <= PWDATA[PME_BIT];
    end
  end

  // ========================================================
  // supply request decode
  logic seated;
  logic [1:0] next_vcc;
  logic [1:0] next_vpp;

  // both detects low means card fully seated
  assign seated = !CD1_B && !CD2_B;

  // supply and programming requests from the active layout
  always_comb
  begin
    next_vcc = VCC_OFF;
    next_vpp = VPP_OFF;
    if (orig)
    begin
      if (pwr_view[SUPEN_BIT])
        next_vcc = sys_sel ? VCC_3V3 : VCC_5V;
      if (pwr_view[AUTO_BIT] && !seated)
        next_vcc = VCC_OFF;
    end
    else
    begin
      case (pwr_view[VCC_LSB +: 2])
        2'h2: next_vcc = VCC_5V;
        2'h3: next_vcc = VCC_3V3;
        default: next_vcc = VCC_OFF;
      endcase
    end
    // prog field only counts with supply on
    if (next_vcc != VCC_OFF)
    begin
      case (pwr_view[VPP_LSB +: 2])
        2'h2: next_vpp = VPP_12V;
        2'h1: next_vpp = orig ? VPP_VCC : VPP_OFF;
        default: next_vpp = VPP_OFF;
      endcase
    end
  end

  // registered requests to switch and card interface
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      SUPPLY_VOLTAGE_REQUEST <= VCC_OFF;
      PROG_VOLTAGE_REQUEST <= VPP_OFF;
      CARD_OUTPUT_ENABLE <= 1'b0;
    end
    else if (CE)
    begin
      SUPPLY_VOLTAGE_REQUEST <= next_vcc;
      PROG_VOLTAGE_REQUEST <= next_vpp;
      // low keeps card pins undriven
      CARD_OUTPUT_ENABLE <= pwr_view[COE_BIT];
    end
  end

  // ========================================================
  // read data and bus answer
  logic [7:0] sts;
  logic [7:0] next_rbyte;

  // interface status byte
  always_comb
  begin
    sts = 8'h00;
    sts[PFLAG_BIT] = (SUPPLY_VOLTAGE_REQUEST != VCC_OFF);
    sts[CD2_BIT] = !CD2_B;
    sts[CD1_BIT] = !CD1_B;
  end

  // read multiplexer
  always_comb
  begin
    next_rbyte = 8'h00;
    if (sel_sts)
      next_rbyte = sts;
    else if (sel_pwr)
      next_rbyte = pwr_view;
    else if (sel_igc)
      next_rbyte = igc;
    else if (sel_cfg)
      next_rbyte = {2'h0, pme_en, sys_sel, cfg_rev};
  end

  // zero-wait answer, error on unmapped words
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= '0;
    end
    else if (CE)
    begin
      PREADY <= setup;
      PSLVERR <= setup && !mapped;
      if (setup)
        PRDATA <= {24'h000000, next_rbyte};
    end
  end

  // ========================================================
  // checks
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_B);

  sequence rd_pwr_s;
    CE && setup && !PWRITE && sel_pwr;
  endsequence

  sequence bus_rst_pme_s;
    CE && !BUS_RESET_INPUT_B && pme_en;
  endsequence

  sequence vcc_3v3_s;
    CE && !orig && pwr_view[VCC_LSB +: 2] == 2'h3;
  endsequence

  // output enable follows bit 7
  out_enable_a: assert property (CE |=> CARD_OUTPUT_ENABLE == $past(pwr_ctl[COE_BIT]))
    else $error("card output enable does not follow bit 7");

  // original layout bit 6 reads zero
  orig_bit6_a: assert property (rd_pwr_s ##0 orig |=> PRDATA[6] == 1'b0)
    else $error("reserved bit 6 read nonzero");

  // auto switching with no card removes supply
  auto_off_a: assert property (
    CE && orig && pwr_view[AUTO_BIT] && !seated |=> SUPPLY_VOLTAGE_REQUEST == VCC_OFF)
    else $error("supply on with auto switching and no card");

  // supply enable picks level from select
  orig_supply_a: assert property (
    CE && orig && !pwr_view[AUTO_BIT] && pwr_view[SUPEN_BIT]
    |=> SUPPLY_VOLTAGE_REQUEST == ($past(sys_sel) ? VCC_3V3 : VCC_5V))
    else $error("supply level wrong in original layout");

  // original layout bits 3..2 read zero
  orig_b32_a: assert property (rd_pwr_s ##0 orig |=> PRDATA[3:2] == 2'h0)
    else $error("reserved bits 3..2 read nonzero");

  // prog request equal to supply decode
  orig_vpp_a: assert property (
    CE && orig && next_vcc != VCC_OFF && pwr_view[1:0] == 2'h1
    |=> PROG_VOLTAGE_REQUEST == VPP_VCC)
    else $error("prog request not equal to supply");

  // no prog voltage without supply
  vpp_gate_a: assert property (
    PROG_VOLTAGE_REQUEST != VPP_OFF |-> SUPPLY_VOLTAGE_REQUEST != VCC_OFF)
    else $error("prog voltage requested with supply off");

  // pm bits hold across bus reset with pme
  pm_hold_a: assert property (
    bus_rst_pme_s |=> (pwr_ctl & $past(pmmask)) == ($past(pwr_ctl) & $past(pmmask)))
    else $error("pm sensitive bits lost on bus reset");

  // later layout reserved bits read zero
  later_rsvd_a: assert property (
    rd_pwr_s ##0 !orig |=> PRDATA[6:5] == 2'h0 && PRDATA[2] == 1'b0)
    else $error("later layout reserved bits nonzero");

  // later supply 11 gives 3.3 V for two cycles
  later_vcc_a: assert property (
    vcc_3v3_s ##1 vcc_3v3_s |-> (SUPPLY_VOLTAGE_REQUEST == VCC_3V3) [*2])
    else $error("supply 11 did not give 3.3 V");

  // later prog 11 gives no voltage
  later_vpp_a: assert property (
    CE && !orig && pwr_view[1:0] == 2'h3 |=> PROG_VOLTAGE_REQUEST == VPP_OFF)
    else $error("reserved prog code drove a voltage");

  // reset values after global reset
  reset_val_a: assert property (
    $rose(RST_B) |-> pwr_ctl == PWR_RST && igc == IGC_RST && cfg_rev == REV_RST)
    else $error("reset values wrong");

  // status flag mirrors supply request
  pwr_flag_a: assert property (
    CE && setup && !PWRITE && sel_sts
    |=> PRDATA[PFLAG_BIT] == ($past(SUPPLY_VOLTAGE_REQUEST) != VCC_OFF))
    else $error("power flag wrong");

  // later supply 10 gives 5 V
  later_5v_a: assert property (
    CE && !orig && pwr_view[VCC_LSB +: 2] == 2'h2 |=> SUPPLY_VOLTAGE_REQUEST == VCC_5V)
    else $error("supply 10 did not give 5 V");

  // later prog ignored while supply 0 V
  later_vpp_gate_a: assert property (
    CE && !orig && pwr_view[VCC_LSB +: 2] < 2'h2 |=> PROG_VOLTAGE_REQUEST == VPP_OFF)
    else $error("prog voltage with later supply off");

  // bus reset without pme clears both registers
  bus_clear_a: assert property (
    CE && !BUS_RESET_INPUT_B && !pme_en |=> pwr_ctl == PWR_RST && igc == IGC_RST)
    else $error("bus reset did not clear registers");

  // general control write lands whole
  igc_write_a: assert property (
    CE && wr && sel_igc && BUS_RESET_INPUT_B |=> igc == $past(PWDATA[7:0]))
    else $error("general control write lost");

endmodule // cspc_top

// *** bench/cspc_card.sv ***
`timescale 1ns/1ns
// ==========================================================
// card and supply switch model
module cspc_card
(
  input wire logic present,
  input wire logic [1:0] supply,
  input wire logic [1:0] prog,
  output logic cd1_b,
  output logic cd2_b,
  output logic fault
);
  // detect pins are pulled high while no card is seated
  assign cd1_b = !present;
  assign cd2_b = !present;
  // prog voltage on an unpowered socket is a hazard
  assign fault = (prog != 2'h0) && (supply == 2'h0);
endmodule // cspc_card

// *** bench/tb_cspc_top.sv ***
`timescale 1ns/1ns
module tb_cspc_top;
  import cspc_pkg::*;
  logic MCLK = 0;
  logic RST_B = 0;
  logic PSEL = 0;
  logic PENABLE = 0;
  logic PWRITE = 0;
  logic BUS_RST_B = 1;
  logic present = 1;
  logic [13:0] PADDR = '0;
  logic [31:0] PWDATA = '0;
  logic [31:0] PRDATA, rd;
  logic PREADY, PSLVERR, oe, err, fault;
  logic [1:0] sup, prg;
  logic cd1_b, cd2_b;
  logic ce = 1;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  // ==========================================================
  // clock, design and card
  always #25 MCLK = ~MCLK;
  cspc_top #(.ADDR_W(14), .CARD_B(1'b0)) DUT (.MCLK(MCLK), .RST_B(RST_B), .CE(ce),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PSTRB(4'hF), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .BUS_RESET_INPUT_B(BUS_RST_B), .CD1_B(cd1_b), .CD2_B(cd2_b),
    .CARD_OUTPUT_ENABLE(oe), .SUPPLY_VOLTAGE_REQUEST(sup), .PROG_VOLTAGE_REQUEST(prg));
  cspc_card card (.present(present), .supply(sup), .prog(prg), .cd1_b(cd1_b),
    .cd2_b(cd2_b), .fault(fault));
  // ==========================================================
  // tasks
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value %s exp %h got %h", what, exp, got);
    end
  endtask
  // one apb transfer, held until pready is seen high
  task apb(input logic w, input logic [11:0] idx, input logic [7:0] d);
    @(posedge MCLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= {idx, 2'b00};
    PWDATA <= {24'h0, d};
    @(posedge MCLK);
    PENABLE <= 1'b1;
    // pready high ends this wait, the bench timeout ends a hang
    do
    begin
      @(posedge MCLK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task wr(input logic [11:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask
  task rdc(input logic [11:0] idx, input logic [7:0] exp, input string what);
    apb(1'b0, idx, 8'h00);
    chk(what, {24'h0, exp}, rd);
  endtask
  // outputs land one edge after the register
  task outc(input logic e, input logic [1:0] s, input logic [1:0] p);
    @(posedge MCLK);
    @(negedge MCLK);
    chk("oe", e, oe);
    chk("supply", s, sup);
    chk("prog", p, prg);
    chk("fault", 0, fault);
  endtask
  task busrst;
    @(posedge MCLK);
    BUS_RST_B <= 1'b0;
    repeat (2) @(posedge MCLK);
    BUS_RST_B <= 1'b1;
  endtask
  // a hang counts as a mismatch
  always @(posedge MCLK)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      stop_test();
    end
  end
  // ==========================================================
  // test sequence
  initial
  begin
    repeat (12) @(posedge MCLK);
    RST_B <= 1'b1;
    rdc(PWR_IDX, 8'h00, "pwr");
    rdc(IGC_IDX, 8'h00, "igc");
    rdc(CFG_IDX, 8'h04, "cfg");
    outc(0, 0, 0);
    $display("reset test done");
    wr(PWR_IDX, 8'hFF);
    rdc(PWR_IDX, 8'h9B, "pwr");
    outc(1, 2'h3, 2'h0);
    for (int v = 0; v < 4; v++)
    begin
      wr(PWR_IDX, 8'h82 | 8'(v << 3));
      outc(1, (v >= 2) ? 2'(v) : 2'h0, (v >= 2) ? 2'h2 : 2'h0);
      rdc(STS_IDX, {1'b0, v >= 2, 6'h0C}, "sts");
    end
    $display("later layout test done");
    wr(LEG_PWR_IDX, 8'h90);
    rdc(PWR_IDX, 8'h90, "alias");
    wr(LEG_IGC_IDX, 8'hA5);
    rdc(IGC_IDX, 8'hA5, "igc");
    apb(1'b0, 12'h7FF, 8'h00);
    chk("slverr", 1, err);
    busrst();
    rdc(PWR_IDX, 8'h00, "pwr");
    rdc(IGC_IDX, 8'h00, "igc");
    wr(CFG_IDX, 8'h24);
    wr(PWR_IDX, 8'h9A);
    wr(IGC_IDX, 8'hFF);
    busrst();
    rdc(PWR_IDX, 8'h9A, "pwr pm");
    rdc(IGC_IDX, 8'h60, "igc pm");
    $display("map and bus reset test done");
    wr(CFG_IDX, 8'h02);
    rdc(PWR_IDX, 8'h92, "pwr");
    wr(PWR_IDX, 8'hFF);
    rdc(PWR_IDX, 8'hB3, "pwr");
    outc(1, 2'h2, 2'h0);
    wr(PWR_IDX, 8'h91);
    outc(1, 2'h2, 2'h1);
    wr(PWR_IDX, 8'h82);
    outc(1, 2'h0, 2'h0);
    wr(CFG_IDX, 8'h12);
    wr(PWR_IDX, 8'h92);
    outc(1, 2'h3, 2'h2);
    wr(PWR_IDX, 8'hB2);
    present <= 1'b0;
    rdc(STS_IDX, 8'h00, "sts");
    outc(1, 2'h0, 2'h0);
    wr(PWR_IDX, 8'h92);
    outc(1, 2'h3, 2'h2);
    wr(PWR_IDX, 8'h12);
    outc(0, 2'h3, 2'h2);
    $display("original layout test done");
    // clock enable low freezes state through a bus reset
    @(posedge MCLK);
    present <= 1'b1;
    ce <= 1'b0;
    busrst();
    ce <= 1'b1;
    outc(0, 2'h3, 2'h2);
    rdc(PWR_IDX, 8'h12, "pwr frozen");
    $display("clock enable test done");
    @(posedge MCLK);
    RST_B <= 1'b0;
    @(posedge MCLK);
    RST_B <= 1'b1;
    rdc(PWR_IDX, 8'h00, "pwr");
    rdc(CFG_IDX, 8'h04, "cfg");
    outc(0, 0, 0);
    $display("global reset test done");
    stop_test();
  end
endmodule // tb_cspc_top
